/* inc/snf_defs.vh */
`ifndef SNF_DEFS_VH
`define SNF_DEFS_VH

`define SNF_OPC_LATCH_SET 8'h06
`define SNF_OPC_LATCH_CLR 8'h04
`define SNF_OPC_STAT_RD 8'h05
`define SNF_OPC_STAT_WR 8'h01
`define SNF_OPC_MEM_RD_LO 4'h3
`define SNF_OPC_MEM_WR_LO 4'h2
`define SNF_OPC_MEM_A8_BIT 3

`define SNF_ST_LATCH_BIT 1
`define SNF_ST_GUARD_LO_BIT 2
`define SNF_ST_GUARD_HI_BIT 3
`define SNF_GUARD_RESET 2'h0

`define SNF_ADDR_W 9
`define SNF_DATA_W 8
`define SNF_QUARTER_BASE 9'h180
`define SNF_HALF_BASE 9'h100
`define SNF_BUF_W 17

`endif

/* core/snf_wbuf.v */
`include "snf_defs.vh"

module snf_wbuf (
   input wire clk_sys,
   input wire nrst,
   input wire in_valid,
   output wire in_ready,
   input wire [`SNF_BUF_W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [`SNF_BUF_W-1:0] out_data
);
   reg [`SNF_BUF_W-1:0] slot_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;

   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = slot_reg[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         slot_reg[0] <= {`SNF_BUF_W{1'b0}};
         slot_reg[1] <= {`SNF_BUF_W{1'b0}};
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            slot_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule

/* core/snf_front_end.v */
`include "snf_defs.vh"

module snf_front_end (
   input wire clk_sys,
   input wire nrst,
   input wire cs_n,
   input wire sck,
   input wire si,
   input wire wp_n,
   output reg so_out,
   output reg so_oe,
   output reg [`SNF_ADDR_W-1:0] mem_rd_addr,
   input wire [`SNF_DATA_W-1:0] mem_rd_data,
   output wire mem_wr_valid,
   input wire mem_wr_ready,
   output wire [`SNF_ADDR_W-1:0] mem_wr_addr,
   output wire [`SNF_DATA_W-1:0] mem_wr_data,
   output reg write_enable_latch,
   output wire [7:0] device_status,
   output reg spi_mode3,
   output reg wr_overrun
);
   localparam [6:0] ST_OPC = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_MRD = 7'h04;
   localparam [6:0] ST_MWR = 7'h08;
   localparam [6:0] ST_SRD = 7'h10;
   localparam [6:0] ST_SWR = 7'h20;
   localparam [6:0] ST_IDLE = 7'h40;

   reg cs_n_prev_reg;
   reg sck_prev_reg;
   reg [6:0] state_reg;
   reg [6:0] state_next;
   reg [2:0] bit_cnt_reg;
   reg [2:0] bit_cnt_next;
   reg [2:0] out_cnt_reg;
   reg [2:0] out_cnt_next;
   reg [7:0] sh_in_reg;
   reg [7:0] sh_in_next;
   reg [7:0] sh_out_reg;
   reg [7:0] sh_out_next;
   reg [`SNF_ADDR_W-1:0] addr_reg;
   reg [`SNF_ADDR_W-1:0] addr_next;
   reg rd_cmd_reg;
   reg rd_cmd_next;
   reg blocked_reg;
   reg blocked_next;
   reg clr_pend_reg;
   reg clr_pend_next;
   reg [1:0] guard_reg;
   reg [1:0] guard_next;
   reg wel_next;
   reg mode3_next;
   reg so_out_next;
   reg so_oe_next;
   reg push_reg;
   reg push_next;
   reg [`SNF_BUF_W-1:0] push_data_reg;
   reg [`SNF_BUF_W-1:0] push_data_next;

   wire sel;
   wire cs_fall;
   wire cs_rise;
   wire sck_rise;
   wire sck_fall;
   wire [7:0] byte_in;
   wire byte_done;
   wire buf_in_ready;

   // Guard field decode, used only by the write check
   function guarded;
      input [`SNF_ADDR_W-1:0] a;
      input [1:0] g;
      begin
         case (g)
            2'h0: guarded = 1'b0;
            2'h1: guarded = (a >= `SNF_QUARTER_BASE);
            2'h2: guarded = (a >= `SNF_HALF_BASE);
            default: guarded = 1'b1;
         endcase
      end
   endfunction

   // Memory opcode decode: returns 1 if high nibble is zero and low three bits match
   function mem_opc;
      input [7:0] op;
      input [3:0] lo;
      begin
         mem_opc = (op[7:4] == 4'h0) && (op[2:0] == lo[2:0]);
      end
   endfunction

   assign sel = ~cs_n;
   assign cs_fall = cs_n_prev_reg & ~cs_n;
   assign cs_rise = ~cs_n_prev_reg & cs_n;
   // An edge coinciding with select fall is not counted: mode 3 starts high
   assign sck_rise = sel & ~cs_fall & sck & ~sck_prev_reg;
   assign sck_fall = sel & ~cs_fall & ~sck & sck_prev_reg;
   assign byte_in = {sh_in_reg[6:0], si};
   assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
   assign device_status = {4'h0, guard_reg, write_enable_latch, 1'b0};

   always @* begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      out_cnt_next = out_cnt_reg;
      sh_in_next = sh_in_reg;
      sh_out_next = sh_out_reg;
      addr_next = addr_reg;
      rd_cmd_next = rd_cmd_reg;
      blocked_next = blocked_reg;
      clr_pend_next = clr_pend_reg;
      guard_next = guard_reg;
      wel_next = write_enable_latch;
      mode3_next = spi_mode3;
      so_out_next = so_out;
      so_oe_next = so_oe;
      push_next = 1'b0;
      push_data_next = push_data_reg;

      if (cs_fall) begin
         state_next = ST_OPC;
         bit_cnt_next = 3'h0;
         out_cnt_next = 3'h0;
         sh_in_next = 8'h00;
         mode3_next = sck;
         clr_pend_next = 1'b0;
         blocked_next = 1'b0;
         so_oe_next = 1'b0;
      end else if (cs_rise || !sel) begin
         state_next = ST_IDLE;
         so_oe_next = 1'b0;
         if (cs_rise && clr_pend_reg) begin
            wel_next = 1'b0;
         end
         clr_pend_next = 1'b0;
      end else begin
         if (sck_rise) begin
            sh_in_next = byte_in;
            bit_cnt_next = bit_cnt_reg + 3'h1;
         end
         if (byte_done) begin
            case (state_reg)
               ST_OPC: begin
                  if (byte_in == `SNF_OPC_LATCH_SET) begin
                     wel_next = 1'b1;
                     state_next = ST_IDLE;
                  end else if (byte_in == `SNF_OPC_LATCH_CLR) begin
                     clr_pend_next = 1'b1;
                     state_next = ST_IDLE;
                  end else if (byte_in == `SNF_OPC_STAT_RD) begin
                     state_next = ST_SRD;
                  end else if (byte_in == `SNF_OPC_STAT_WR) begin
                     clr_pend_next = 1'b1;
                     state_next = ST_SWR;
                  end else if (mem_opc(byte_in, `SNF_OPC_MEM_RD_LO)) begin
                     addr_next = {byte_in[`SNF_OPC_MEM_A8_BIT], 8'h00};
                     rd_cmd_next = 1'b1;
                     state_next = ST_ADDR;
                  end else if (mem_opc(byte_in, `SNF_OPC_MEM_WR_LO)) begin
                     addr_next = {byte_in[`SNF_OPC_MEM_A8_BIT], 8'h00};
                     rd_cmd_next = 1'b0;
                     clr_pend_next = 1'b1;
                     state_next = ST_ADDR;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
               ST_ADDR: begin
                  addr_next = {addr_reg[8], byte_in};
                  state_next = rd_cmd_reg ? ST_MRD : ST_MWR;
               end
               ST_MWR: begin
                  if (write_enable_latch && wp_n && !blocked_reg && !guarded(addr_reg, guard_reg)) begin
                     push_next = 1'b1;
                     push_data_next = {addr_reg, byte_in};
                     addr_next = addr_reg + 9'h001;
                  end else begin
                     // A protected address freezes the burst for the rest of the frame
                     blocked_next = 1'b1;
                  end
               end
               ST_SWR: begin
                  if (write_enable_latch && wp_n) begin
                     guard_next = {byte_in[`SNF_ST_GUARD_HI_BIT], byte_in[`SNF_ST_GUARD_LO_BIT]};
                  end
                  state_next = ST_IDLE;
               end
               default: begin
                  state_next = state_reg;
               end
            endcase
         end
         if (sck_fall && (state_reg == ST_SRD || state_reg == ST_MRD)) begin
            out_cnt_next = out_cnt_reg + 3'h1;
            so_oe_next = 1'b1;
            if (out_cnt_reg == 3'h0) begin
               if (state_reg == ST_SRD) begin
                  sh_out_next = {device_status[6:0], 1'b0};
                  so_out_next = device_status[7];
               end else begin
                  sh_out_next = {mem_rd_data[6:0], 1'b0};
                  so_out_next = mem_rd_data[7];
                  addr_next = addr_reg + 9'h001;
               end
            end else begin
               sh_out_next = {sh_out_reg[6:0], 1'b0};
               so_out_next = sh_out_reg[7];
            end
         end
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cs_n_prev_reg <= 1'b1;
         sck_prev_reg <= 1'b0;
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
         out_cnt_reg <= 3'h0;
         sh_in_reg <= 8'h00;
         sh_out_reg <= 8'h00;
         addr_reg <= 9'h000;
         rd_cmd_reg <= 1'b0;
         blocked_reg <= 1'b0;
         clr_pend_reg <= 1'b0;
         guard_reg <= `SNF_GUARD_RESET;
         write_enable_latch <= 1'b0;
         spi_mode3 <= 1'b0;
         so_out <= 1'b0;
         so_oe <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= {`SNF_BUF_W{1'b0}};
         mem_rd_addr <= 9'h000;
         wr_overrun <= 1'b0;
      end else begin
         cs_n_prev_reg <= cs_n;
         sck_prev_reg <= sck;
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         out_cnt_reg <= out_cnt_next;
         sh_in_reg <= sh_in_next;
         sh_out_reg <= sh_out_next;
         addr_reg <= addr_next;
         rd_cmd_reg <= rd_cmd_next;
         blocked_reg <= blocked_next;
         clr_pend_reg <= clr_pend_next;
         guard_reg <= guard_next;
         write_enable_latch <= wel_next;
         spi_mode3 <= mode3_next;
         so_out <= so_out_next;
         so_oe <= so_oe_next;
         push_reg <= push_next;
         push_data_reg <= push_data_next;
         mem_rd_addr <= addr_next;
         // SPI master cannot be stalled; a third word while both slots wait is flagged
         wr_overrun <= push_reg & ~buf_in_ready;
      end
   end

   snf_wbuf u_wbuf (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(push_reg),
      .in_ready(buf_in_ready),
      .in_data(push_data_reg),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data({mem_wr_addr, mem_wr_data})
   );
endmodule

/* dv/snf_front_end_props.sv */
module snf_front_end_props (
   input wire clk_sys,
   input wire nrst,
   input wire cs_n,
   input wire sck,
   input wire wp_n,
   input wire so_out,
   input wire so_oe,
   input wire mem_wr_valid,
   input wire write_enable_latch,
   input wire [7:0] device_status,
   input wire spi_mode3,
   input wire wr_overrun
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_idle_no_drive: assert property (cs_n [*3] |-> !so_oe)
      else $error("output driven while deselected");
   a_status_fixed_zero: assert property (device_status[0] == 1'b0 && device_status[7:4] == 4'h0)
      else $error("fixed status bits not zero");
   a_latch_in_status: assert property (device_status[1] == write_enable_latch)
      else $error("status latch bit differs from latch");
   a_latch_set_framed: assert property ($rose(write_enable_latch) |-> !$past(cs_n))
      else $error("latch set outside a frame");
   a_latch_clear_rise: assert property ($fell(write_enable_latch) |-> $past(cs_n) || $past(cs_n, 2))
      else $error("latch cleared away from select rise");
   a_mode_capture: assert property ($fell(cs_n) |-> ##2 spi_mode3 == $past(sck, 2))
      else $error("mode not taken from clock level");
   a_mode_steady: assert property (!cs_n [*4] |-> $stable(spi_mode3))
      else $error("mode changed inside frame");
   a_guard_needs_latch: assert property ($changed(device_status[3:2]) |-> $past(write_enable_latch) && $past(wp_n))
      else $error("guard bits changed without permission");
   a_write_unprotected: assert property ($rose(mem_wr_valid) |-> $past(wp_n, 2))
      else $error("array write while protect pin low");
   // Output may only move shortly after a falling serial clock
   a_shift_on_fall: assert property ($changed(so_out) && !cs_n |-> !$past(sck) || !$past(sck, 2))
      else $error("output changed on rising clock");
   c_latch_set: cover property ($rose(write_enable_latch));
   c_overrun: cover property (wr_overrun);
   c_mode3_frame: cover property ($fell(cs_n) && sck);
endmodule

/* dv/snf_spi_master.sv */
module snf_spi_master (
   input wire clk_sys,
   input wire so_out,
   output logic cs_n,
   output logic sck,
   output logic si
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Levels held 3 clk so the oversampler sees every edge
   task automatic frame(input logic m3, input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx = 64'h0;
      sck = m3;
      ticks(3);
      cs_n = 1'b0;
      ticks(3);
      for (int i = 0; i < 8 * n; i++) begin
         sck = 1'b0;
         si = tx[63 - i];
         ticks(3);
         rx[63 - i] = so_out;
         sck = 1'b1;
         ticks(3);
      end
      if (!m3) begin
         sck = 1'b0;
         ticks(3);
      end
      cs_n = 1'b1;
      si = ~si;
      ticks(4);
   endtask
endmodule

/* dv/snf_front_end_test.sv */
module snf_front_end_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic wp_n = 1'b1;
   logic mem_wr_ready = 1'b1;
   wire cs_n, sck, si, so_out, so_oe, mem_wr_valid, write_enable_latch, spi_mode3, wr_overrun;
   wire [8:0] mem_rd_addr, mem_wr_addr;
   wire [7:0] mem_wr_data, device_status;
   // Array stand-in: contents are a fixed function of the address
   wire [7:0] mem_rd_data = mem_rd_addr[7:0] ^ {mem_rd_addr[8], 7'h35};
   logic [63:0] rx;
   logic [16:0] wq[$];
   int failures = 0;
   int n_tests = 0;
   int n_ovr = 0;
   always #20 clk_sys = ~clk_sys;
   snf_front_end u_snf_front_end (.clk_sys, .nrst, .cs_n, .sck, .si, .wp_n, .so_out, .so_oe, .mem_rd_addr,
      .mem_rd_data, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .write_enable_latch,
      .device_status, .spi_mode3, .wr_overrun);
   snf_spi_master u_snf_spi_master (.clk_sys, .so_out, .cs_n, .sck, .si);
   always @(posedge clk_sys) begin
      if (mem_wr_valid === 1'b1 && mem_wr_ready)
         wq.push_back({mem_wr_addr, mem_wr_data});
      if (wr_overrun === 1'b1)
         n_ovr++;
   end
   task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic expect_wr(input logic [16:0] exp);
      check("array write", wq.size() > 0 ? wq.pop_front() : 17'h0, exp);
   endtask
   task automatic cmd(input logic m3, input int n, input logic [63:0] tx);
      u_snf_spi_master.frame(m3, n, tx, rx);
   endtask
   task automatic stat_wr(input logic [7:0] v);
      cmd(1'b0, 1, {8'h06, 56'h0});
      cmd(1'b0, 2, {8'h01, v, 48'h0});
   endtask
   task automatic t_reset;
      check("status", device_status, 8'h00);
      check("latch", write_enable_latch, 1'b0);
      check("so_oe", so_oe, 1'b0);
   endtask
   task automatic t_latch;
      cmd(1'b1, 1, {8'h06, 56'h0});
      check("mode3", spi_mode3, 1'b1);
      check("latch set", write_enable_latch, 1'b1);
      cmd(1'b0, 2, {8'h05, 56'h0});
      check("mode0", spi_mode3, 1'b0);
      check("status read", rx[55:48], 8'h02);
      cmd(1'b0, 1, {8'h04, 56'h0});
      check("latch clear", write_enable_latch, 1'b0);
   endtask
   task automatic t_status;
      wp_n = 1'b0;
      stat_wr(8'hFF);
      check("status wp", device_status, 8'h00);
      wp_n = 1'b1;
      stat_wr(8'hFF);
      check("status write", device_status, 8'h0C);
      cmd(1'b0, 2, {8'h01, 8'h00, 48'h0});
      check("status no latch", device_status, 8'h0C);
   endtask
   task automatic t_guard;
      cmd(1'b0, 1, {8'h06, 56'h0});
      cmd(1'b0, 3, {8'h02, 8'h00, 8'h55, 40'h0});
      check("all guarded", wq.size(), 17'h0);
      stat_wr(8'h04);
      cmd(1'b0, 1, {8'h06, 56'h0});
      cmd(1'b0, 4, {8'h0A, 8'h7F, 8'h11, 8'h22, 32'h0});
      check("quarter guard", wq.size(), 17'h1);
      expect_wr({9'h17F, 8'h11});
      check("latch after write", write_enable_latch, 1'b0);
   endtask
   task automatic t_stall;
      stat_wr(8'h00);
      mem_wr_ready = 1'b0;
      cmd(1'b0, 1, {8'h06, 56'h0});
      cmd(1'b0, 5, {8'h0A, 8'hFF, 8'hA1, 8'hB2, 8'hC3, 24'h0});
      check("overrun", 17'(n_ovr), 17'h1);
      mem_wr_ready = 1'b1;
      u_snf_spi_master.ticks(4);
      expect_wr({9'h1FF, 8'hA1});
      expect_wr({9'h000, 8'hB2});
   endtask
   task automatic t_read;
      cmd(1'b1, 4, {8'h0B, 8'hFF, 48'h0});
      check("read 1FF", rx[47:40], 8'hFF ^ 8'hB5);
      check("read wrap", rx[39:32], 8'h00 ^ 8'h35);
      check("so released", so_oe, 1'b0);
   endtask
   task automatic t_opcode;
      cmd(1'b0, 2, {8'h06, 8'h04, 48'h0});
      check("one opcode", write_enable_latch, 1'b1);
      cmd(1'b0, 2, {8'h07, 8'h04, 48'h0});
      check("invalid ignored", write_enable_latch, 1'b1);
      cmd(1'b0, 1, {8'h04, 56'h0});
   endtask
   task automatic results;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      nrst = 1'b1;
      u_snf_spi_master.ticks(4);
      t_reset;
      t_latch;
      t_status;
      t_guard;
      t_stall;
      t_read;
      t_opcode;
      results;
   end
   // Whole run needs well under 150 us
   initial begin
      #400000;
      failures++;
      results;
   end
endmodule
bind snf_front_end snf_front_end_props u_snf_front_end_props (.clk_sys, .nrst, .cs_n, .sck, .wp_n, .so_out,
   .so_oe, .mem_wr_valid, .write_enable_latch, .device_status, .spi_mode3, .wr_overrun);
